/* File: hw/arb_if.sv */
/*
  Request and grant bundle between the interrupt map and its arbiter.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface arb_if;
  import irq_map_pkg::*;
  logic [NUM_ORDERS-1:0] req;
  logic [NUM_ORDERS-1:0] high_sel;
  logic                  valid;
  logic                  high;
  logic [ORDER_W-1:0]    order;
  modport requester (output req, output high_sel, input valid, input high, input order);
  modport arbiter   (input req, input high_sel, output valid, output high, output order);
endinterface
`default_nettype wire

/* File: hw/irq_arbiter.sv */
/*
  Two-level fixed-order arbiter, purely combinational.
  Assumes requests already gated by masks and global enable.
*/
`timescale 1ns/1ps
`default_nettype none
module irq_arbiter
  import irq_map_pkg::*;
(
  arb_if.arbiter arb
);
  logic [NUM_ORDERS-1:0] high_req;

  always_comb begin
    high_req  = arb.req & arb.high_sel;
    arb.valid = |arb.req;
    arb.high  = |high_req;
    // high level first, then lowest order inside the level [R21]
    arb.order = (|high_req) ? lowest(high_req) : lowest(arb.req);
  end
endmodule
`default_nettype wire

/* File: hw/irq_map_pkg.sv */
/*
  Constants for the vectored interrupt map: register offsets, bit positions,
  reset values, arbitration orders and vector arithmetic.
  Assumes byte addressing on a 32-bit AXI4-Lite bus, one aligned word per register.
*/
// Functional notes
// R1: reset is non-maskable, has no flag, ranks highest, starts at 0x0000.
// R2: external input zero vectors 0x0003, order 0, hardware-cleared, bit 0 controls.
// R3: timer zero overflow vectors 0x000B, order 1, hardware-cleared, bit 1 controls.
// R4: external input one vectors 0x0013, order 2, hardware-cleared, bit 2 controls.
// R5: timer one overflow vectors 0x001B, order 3, hardware-cleared, bit 3 controls.
// R6: uart requests 0x0023, order 4, from rx or tx done; never hardware-cleared.
// R7: timer two requests 0x002B, order 5, from high or low overflow; not cleared.
// R8: spi requests 0x0033, order 6, from any of four flags; none cleared.
// R9: smbus requests 0x003B, order 7, secondary bit 0; flag not cleared.
// R10: vector 0x0043, order 8, stays reserved with nothing attached.
// R11: converter window compare requests 0x004B, order 9, secondary bit 2.
// R12: converter done requests 0x0053, order 10, secondary bit 3.
// R13: counter array requests 0x005B, order 11, overflow or any module match, bit 4.
// R14: comparator zero requests 0x0063, order 12, fall or rise flag, bit 5.
// R15: comparator one requests 0x006B, order 13, fall or rise flag, bit 6.
// R16: timer three requests 0x0073, order 14, high or low overflow, bit 7.
// R17: global enable bit 7 gates every source; when set each follows its mask.
// R18: primary enable register resets to zero and sits at 0xA8.
// R19: primary enable bit 6 masks all spi flags together.
// R20: primary enable bit 5 lets either timer two overflow flag request.
// R21: high priority wins; equal priority goes to the lower arbitration order.
// R22: flags set regardless of enables; software writing one requests like hardware.
// R23: hardware-cleared flags clear when the core vectors to that source.
// R24: a flag still set after return requests again after one more instruction.
package irq_map_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          NUM_ORDERS    = 15;
  localparam int          ORDER_W       = 4;
  localparam int          PCA_MODULES   = 5;

  localparam logic [7:0]  OFF_EN        = 8'hA8;
  localparam logic [7:0]  OFF_PR        = 8'hB8;
  localparam logic [7:0]  OFF_PENDING   = 8'hC0;
  localparam logic [7:0]  OFF_STATUS    = 8'hC4;
  localparam logic [7:0]  OFF_EIE       = 8'hE4;
  localparam logic [7:0]  OFF_EIP       = 8'hF4;

  localparam logic [7:0]  EN_RESET      = 8'h00;
  localparam logic [7:0]  PR_RESET      = 8'h00;
  localparam logic [7:0]  EIE_RESET     = 8'h00;
  localparam logic [7:0]  EIP_RESET     = 8'h00;
  localparam logic [3:0]  PENDING_RESET = 4'h0;

  localparam int          BIT_GLOBAL    = 7;
  localparam int          BIT_SPI       = 6;
  localparam int          BIT_TIMER2    = 5;
  localparam int          BIT_UART      = 4;
  localparam int          BIT_TIMER1    = 3;
  localparam int          BIT_EXT1      = 2;
  localparam int          BIT_TIMER0    = 1;
  localparam int          BIT_EXT0      = 0;
  localparam int          BIT_SMBUS     = 0;
  localparam int          BIT_ADC_WIN   = 2;
  localparam int          BIT_ADC_DONE  = 3;
  localparam int          BIT_PCA       = 4;
  localparam int          BIT_CMP0      = 5;
  localparam int          BIT_CMP1      = 6;
  localparam int          BIT_TIMER3    = 7;

  localparam int          ORD_EXT0      = 0;
  localparam int          ORD_TIMER0    = 1;
  localparam int          ORD_EXT1      = 2;
  localparam int          ORD_TIMER1    = 3;
  localparam int          ORD_UART      = 4;
  localparam int          ORD_TIMER2    = 5;
  localparam int          ORD_SPI       = 6;
  localparam int          ORD_SMBUS     = 7;
  localparam int          ORD_RESERVED  = 8;
  localparam int          ORD_ADC_WIN   = 9;
  localparam int          ORD_ADC_DONE  = 10;
  localparam int          ORD_PCA       = 11;
  localparam int          ORD_CMP0      = 12;
  localparam int          ORD_CMP1      = 13;
  localparam int          ORD_TIMER3    = 14;

  localparam int          STAT_ORDER_LSB = 16;
  localparam int          STAT_HIGH      = 20;
  localparam int          STAT_REQUEST   = 21;
  localparam int          STAT_HOLD      = 22;

  localparam logic [15:0] RESET_VECTOR  = 16'h0000;
  localparam logic [15:0] VECTOR_BASE   = 16'h0003;
  localparam int          VECTOR_SHIFT  = 3;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // vector of arbitration order n is base plus eight per step
  function automatic logic [15:0] vector_of(input logic [ORDER_W-1:0] ord);
    vector_of = VECTOR_BASE + (16'(ord) << VECTOR_SHIFT);
  endfunction

  // spreads primary and secondary control bytes onto the order-indexed vector
  function automatic logic [NUM_ORDERS-1:0] by_order(input logic [7:0] prim,
                                                     input logic [7:0] sec);
    by_order = {sec[7:2], 1'b0, sec[0], prim[6:0]};
  endfunction

  // lowest set index wins; the caller checks for an empty vector
  function automatic logic [ORDER_W-1:0] lowest(input logic [NUM_ORDERS-1:0] v);
    lowest = '0;
    for (int i = NUM_ORDERS - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowest = ORDER_W'(i);
      end
    end
  endfunction
endpackage

/* File: hw/vectored_interrupt_map.sv */
/*
  Vectored interrupt map: pending flags for hardware-cleared sources, enable and
  priority registers behind an AXI4-Lite slave, and the vector offered to the core.
  Assumes the core pulses vector_ack when it takes the offered vector, reti_done
  when a service routine returns and instr_done after each instruction.
*/
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_map
  import irq_map_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [ADDR_W-1:0]      s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   ext_input_zero,
  input  wire logic                   timer0_event,
  input  wire logic                   ext_input_one,
  input  wire logic                   timer1_event,
  input  wire logic                   uart_rx_done,
  input  wire logic                   uart_tx_done,
  input  wire logic                   timer2_high_overflow,
  input  wire logic                   timer2_low_overflow,
  input  wire logic                   spi_transfer_done,
  input  wire logic                   spi_write_collision,
  input  wire logic                   spi_mode_fault,
  input  wire logic                   spi_rx_overrun,
  input  wire logic                   smbus_event_flag,
  input  wire logic                   converter_window_hit,
  input  wire logic                   converter_done,
  input  wire logic                   counter_array_overflow,
  input  wire logic [PCA_MODULES-1:0] counter_module_match,
  input  wire logic                   cmp0_fall_flag,
  input  wire logic                   cmp0_rise_flag,
  input  wire logic                   cmp1_fall_flag,
  input  wire logic                   cmp1_rise_flag,
  input  wire logic                   timer3_high_overflow,
  input  wire logic                   timer3_low_overflow,
  input  wire logic                   vector_ack,
  input  wire logic                   reti_done,
  input  wire logic                   instr_done,
  output logic                        irq_request,
  output logic [15:0]                 irq_vector,
  output logic [ORDER_W-1:0]          irq_order,
  output logic                        irq_high,
  output logic [15:0]                 boot_vector,
  output logic [3:0]                  hw_pending
);
  arb_if arb ();

  irq_arbiter u_arbiter (
    .arb (arb.arbiter)
  );

  // register state
  logic [7:0]            interrupt_enable_primary;
  logic [7:0]            primary_priority_reg;
  logic [7:0]            secondary_enable_reg;
  logic [7:0]            secondary_priority_reg;
  logic [3:0]            pending;
  logic [7:0]            next_en;
  logic [7:0]            next_pr;
  logic [7:0]            next_eie;
  logic [7:0]            next_eip;
  logic [3:0]            next_pending;

  // bus state
  logic                  aw_held;
  logic [ADDR_W-1:0]     aw_addr;
  logic                  w_held;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  b_valid;
  logic [1:0]            b_resp;
  logic                  r_valid;
  logic [31:0]           r_data;
  logic [1:0]            r_resp;
  logic                  next_aw_held;
  logic [ADDR_W-1:0]     next_aw_addr;
  logic                  next_w_held;
  logic [31:0]           next_w_data;
  logic [3:0]            next_w_strb;
  logic                  next_b_valid;
  logic [1:0]            next_b_resp;
  logic                  next_r_valid;
  logic [31:0]           next_r_data;
  logic [1:0]            next_r_resp;

  // request state
  logic                  hold_off;
  logic                  req_q;
  logic [15:0]           vector_q;
  logic [ORDER_W-1:0]    order_q;
  logic                  high_q;
  logic                  next_hold_off;
  logic                  next_req;
  logic [15:0]           next_vector;
  logic [ORDER_W-1:0]    next_order;
  logic                  next_high;

  logic                  do_write;
  logic                  wr_byte;
  logic                  aw_ok;
  logic [NUM_ORDERS-1:0] raw_flags;
  logic [NUM_ORDERS-1:0] masks;
  logic [NUM_ORDERS-1:0] masked;
  logic [3:0]            hw_events;
  logic [3:0]            ack_clear;
  logic [31:0]           status_word;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == OFF_EN) || (a == OFF_PR) || (a == OFF_PENDING) ||
             (a == OFF_STATUS) || (a == OFF_EIE) || (a == OFF_EIP);
  endfunction

  // handshakes stay combinational; one write and one read in flight
  assign s_axi_awready = ~aw_held & ~b_valid;
  assign s_axi_wready  = ~w_held & ~b_valid;
  assign s_axi_arready = ~r_valid;
  assign s_axi_bvalid  = b_valid;
  assign s_axi_bresp   = b_resp;
  assign s_axi_rvalid  = r_valid;
  assign s_axi_rdata   = r_data;
  assign s_axi_rresp   = r_resp;

  assign do_write = aw_held & w_held & ~b_valid;
  assign wr_byte  = do_write & w_strb[0];
  assign aw_ok    = mapped(aw_addr);

  // flag sources: peripherals own the flags they never see cleared here
  always_comb begin
    raw_flags               = '0;
    raw_flags[ORD_EXT0]     = pending[ORD_EXT0];                               // [R2]
    raw_flags[ORD_TIMER0]   = pending[ORD_TIMER0];                             // [R3]
    raw_flags[ORD_EXT1]     = pending[ORD_EXT1];                               // [R4]
    raw_flags[ORD_TIMER1]   = pending[ORD_TIMER1];                             // [R5]
    raw_flags[ORD_UART]     = uart_rx_done | uart_tx_done;                     // [R6]
    raw_flags[ORD_TIMER2]   = timer2_high_overflow | timer2_low_overflow;      // [R7] [R20]
    raw_flags[ORD_SPI]      = spi_transfer_done | spi_write_collision |
                              spi_mode_fault | spi_rx_overrun;                 // [R8] [R19]
    raw_flags[ORD_SMBUS]    = smbus_event_flag;                                // [R9]
    raw_flags[ORD_RESERVED] = 1'b0;                                            // [R10]
    raw_flags[ORD_ADC_WIN]  = converter_window_hit;                            // [R11]
    raw_flags[ORD_ADC_DONE] = converter_done;                                  // [R12]
    raw_flags[ORD_PCA]      = counter_array_overflow | (|counter_module_match); // [R13]
    raw_flags[ORD_CMP0]     = cmp0_fall_flag | cmp0_rise_flag;                 // [R14]
    raw_flags[ORD_CMP1]     = cmp1_fall_flag | cmp1_rise_flag;                 // [R15]
    raw_flags[ORD_TIMER3]   = timer3_high_overflow | timer3_low_overflow;      // [R16]
  end

  // reserved order carries no mask bit, so it can never request
  assign masks = by_order(interrupt_enable_primary, secondary_enable_reg);     // [R10]
  // global enable overrides every individual mask
  assign masked = interrupt_enable_primary[BIT_GLOBAL] ? (raw_flags & masks) : '0; // [R17]

  assign arb.req      = masked;
  assign arb.high_sel = by_order(primary_priority_reg, secondary_priority_reg); // [R21]

  assign hw_events = {timer1_event, ext_input_one, timer0_event, ext_input_zero};

  always_comb begin
    status_word                                     = '0;
    status_word[NUM_ORDERS-1:0]                     = masked;
    status_word[STAT_ORDER_LSB +: ORDER_W]          = order_q;
    status_word[STAT_HIGH]                          = high_q;
    status_word[STAT_REQUEST]                       = req_q;
    status_word[STAT_HOLD]                          = hold_off;
  end

  // clear on vectoring only for the four hardware-cleared sources
  always_comb begin
    ack_clear = '0;
    if (vector_ack && req_q && order_q <= ORDER_W'(ORD_TIMER1)) begin
      ack_clear[order_q[1:0]] = 1'b1;                                          // [R23]
    end
  end

  // register file next state
  always_comb begin
    next_en      = interrupt_enable_primary;
    next_pr      = primary_priority_reg;
    next_eie     = secondary_enable_reg;
    next_eip     = secondary_priority_reg;
    next_pending = pending & ~ack_clear;
    if (wr_byte) begin
      case (aw_addr)
        OFF_EN:      next_en      = w_data[7:0];
        OFF_PR:      next_pr      = {1'b0, w_data[6:0]};
        OFF_EIE:     next_eie     = {w_data[7:2], 1'b0, w_data[0]};
        OFF_EIP:     next_eip     = {w_data[7:2], 1'b0, w_data[0]};
        // software may set a flag and request exactly as hardware would
        OFF_PENDING: next_pending = w_data[3:0];                               // [R22]
        default:     next_pending = pending & ~ack_clear;
      endcase
    end
    // an event landing with a clear still sets the flag, enabled or not
    next_pending = next_pending | hw_events;                                   // [R22]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_enable_primary <= EN_RESET;                                    // [R18]
      primary_priority_reg     <= PR_RESET;
      secondary_enable_reg     <= EIE_RESET;
      secondary_priority_reg   <= EIP_RESET;
      pending                  <= PENDING_RESET;
    end else begin
      interrupt_enable_primary <= next_en;
      primary_priority_reg     <= next_pr;
      secondary_enable_reg     <= next_eie;
      secondary_priority_reg   <= next_eip;
      pending                  <= next_pending;
    end
  end

  // bus next state
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_b_valid = b_valid;
    next_b_resp  = b_resp;
    next_r_valid = r_valid;
    next_r_data  = r_data;
    next_r_resp  = r_resp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_b_valid = 1'b1;
      next_b_resp  = aw_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (b_valid && s_axi_bready) begin
      next_b_valid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_r_valid = 1'b1;
      next_r_resp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFF_EN:      next_r_data = {24'h000000, interrupt_enable_primary};
        OFF_PR:      next_r_data = {24'h000000, primary_priority_reg};
        OFF_EIE:     next_r_data = {24'h000000, secondary_enable_reg};
        OFF_EIP:     next_r_data = {24'h000000, secondary_priority_reg};
        OFF_PENDING: next_r_data = {28'h0000000, pending};
        OFF_STATUS:  next_r_data = status_word;
        default:     next_r_data = 32'h00000000;
      endcase
    end else if (r_valid && s_axi_rready) begin
      next_r_valid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held  <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      b_valid <= 1'b0;
      b_resp  <= RESP_OKAY;
      r_valid <= 1'b0;
      r_data  <= 32'h00000000;
      r_resp  <= RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held  <= next_w_held;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      b_valid <= next_b_valid;
      b_resp  <= next_b_resp;
      r_valid <= next_r_valid;
      r_data  <= next_r_data;
      r_resp  <= next_r_resp;
    end
  end

  // request to the core, sampled once per clock
  always_comb begin
    // after a return the core must run one instruction before re-entering
    if (reti_done) begin
      next_hold_off = 1'b1;                                                    // [R24]
    end else if (instr_done) begin
      next_hold_off = 1'b0;                                                    // [R24]
    end else begin
      next_hold_off = hold_off;
    end
    // drop for the ack cycle so a hardware clear lands before re-sampling
    next_req    = arb.valid & ~next_hold_off & ~vector_ack;                    // [R24]
    next_order  = arb.order;
    next_high   = arb.high;
    next_vector = vector_of(arb.order);                                        // [R2] [R16]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_off <= 1'b0;
      req_q    <= 1'b0;
      vector_q <= RESET_VECTOR;
      order_q  <= '0;
      high_q   <= 1'b0;
    end else begin
      hold_off <= next_hold_off;
      req_q    <= next_req;
      vector_q <= next_vector;
      order_q  <= next_order;
      high_q   <= next_high;
    end
  end

  assign irq_request = req_q;
  assign irq_vector  = vector_q;
  assign irq_order   = order_q;
  assign irq_high    = high_q;
  // reset needs no flag or mask: the core always restarts here
  assign boot_vector = RESET_VECTOR;                                           // [R1]
  assign hw_pending  = pending;
endmodule
`default_nettype wire

/* File: sim/core_model.sv */
/* core sequencer model: takes the vector, returns, runs one instruction
   assumes the map's clock and reset */
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic   aclk, aresetn, irq_request, serve,
  output logic       vector_ack, reti_done, instr_done,
  output logic [3:0] acks
);
  logic [2:0] st;
  logic       go;
  assign go = serve && irq_request && st == 3'h0;
  // flags left set are not cleared here, so a level source comes back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {st, acks, vector_ack, reti_done, instr_done} <= '0;
    end else begin
      vector_ack <= go;
      reti_done <= st == 3'h3;
      instr_done <= st == 3'h4;
      st <= (st == 3'h4) ? 3'h0 : (go || st != 3'h0) ? st + 3'h1 : 3'h0;
      acks <= acks + 4'(go);
    end
  end
endmodule
`default_nettype wire

/* File: sim/tb_vectored_interrupt_map.sv */
/* bench: AXI4-Lite master tasks, flag sources in f, core model on the vector side
   assumes the map's package constants */
`timescale 1ns/1ps
`default_nettype none
module tb_vectored_interrupt_map;
  import irq_map_pkg::*;
  logic        aclk = 0, aresetn = 0, serve = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_val;
  logic [14:0] f [4] = '{default: 15'h0};
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        vector_ack, reti_done, instr_done, irq_request, irq_high;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] irq_vector, boot_vector;
  logic [3:0]  irq_order, hw_pending, acks, a0;
  int          n_errors = 0, tests_run = 0;
  always #50 aclk = ~aclk;
  vectored_interrupt_map i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ext_input_zero(f[0][0]), .timer0_event(f[0][1]),
    .ext_input_one(f[0][2]), .timer1_event(f[0][3]), .uart_rx_done(f[0][4]),
    .uart_tx_done(f[1][4]), .timer2_high_overflow(f[0][5]), .timer2_low_overflow(f[1][5]),
    .spi_transfer_done(f[0][6]), .spi_write_collision(f[1][6]), .spi_mode_fault(f[2][6]),
    .spi_rx_overrun(f[3][6]), .smbus_event_flag(f[0][7]), .converter_window_hit(f[0][9]),
    .converter_done(f[0][10]), .counter_array_overflow(f[0][11]),
    .counter_module_match({5{f[1][11]}}), .cmp0_fall_flag(f[0][12]), .cmp0_rise_flag(f[1][12]),
    .cmp1_fall_flag(f[0][13]), .cmp1_rise_flag(f[1][13]), .timer3_high_overflow(f[0][14]),
    .timer3_low_overflow(f[1][14]), .vector_ack, .reti_done, .instr_done, .irq_request,
    .irq_vector, .irq_order, .irq_high, .boot_vector, .hw_pending);
  core_model i_core (.aclk, .aresetn, .irq_request, .serve, .vector_ack, .reti_done,
    .instr_done, .acks);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task final_report();
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // each valid drops at the edge where its ready is seen; ends when the answer is taken
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    cyc(1);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, 24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
    for (i = 0; i < 50 && !(s_axi_bvalid || s_axi_rvalid); i++) begin
      cyc(1);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end
    rsp = w ? s_axi_bresp : s_axi_rresp;
    rd_val = s_axi_rdata;
    {s_axi_bready, s_axi_rready} <= 2'b00;
    if (i == 50) begin
      n_errors++;
      final_report();
    end
  endtask
  task t_regs();
    chk(boot_vector, 0);
    bus(0, 8'hA8, 0);
    chk({rsp, rd_val[29:0]}, 0);
    bus(0, 8'h10, 0);
    chk(rsp, RESP_SLVERR);
    bus(1, 8'h10, 8'h01);
    chk(rsp, RESP_SLVERR);
  endtask
  task t_gate();
    f[0][6] <= 1;
    bus(1, 8'hA8, 8'h40);
    cyc(3);
    chk(irq_request, 0);
    bus(1, 8'hA8, 8'h80);
    cyc(3);
    chk(irq_request, 0);
    bus(1, 8'hA8, 8'hC0);
    cyc(3);
    chk({irq_request, irq_vector}, 17'h10033);
    f[0][6] <= 0;
    f[0][0] <= 1;
    cyc(1);
    f[0][0] <= 0;
    cyc(3);
    chk({irq_request, hw_pending}, 5'h01);
    bus(1, 8'hC0, 8'h02);
    bus(1, 8'hA8, 8'h82);
    cyc(3);
    chk({irq_request, irq_vector}, 17'h1000B);
    bus(1, 8'hC0, 8'h00);
  endtask
  // every source and every flag of it, alone, the five module matches as one; a level flag must come back after return
  task t_loop();
    bus(1, 8'hA8, 8'hFF);
    bus(1, 8'hE4, 8'hFD);
    for (int j = 0; j < 4; j++)
      for (int o = 0; o < 15; o++) begin
        if (o == 8 || (j > 0 && o inside {[0:3], 7, 9, 10}) || (j > 1 && o != 6)) continue;
        a0 = acks;
        f[j][o] <= 1;
        cyc(1);
        if (o < 4) f[j][o] <= 0;
        cyc(3);
        chk({irq_request, irq_vector}, 32'h10003 + 8 * o);
        serve <= 1;
        cyc(14);
        {serve, f[j][o]} <= 2'b00;
        cyc(8);
        chk(4'(acks - a0) == 4'h1, o < 4);
        chk(hw_pending, 0);
      end
  endtask
  task t_prio();
    {f[0][5], f[0][9]} <= 2'b11;
    cyc(4);
    chk(irq_order, 5);
    bus(1, 8'hF4, 8'h04);
    cyc(3);
    chk({irq_high, irq_order}, 5'h19);
    {f[0][5], f[0][9]} <= 2'b00;
  endtask
  initial begin
    cyc(3);
    aresetn <= 1;
    t_regs();
    t_gate();
    t_loop();
    t_prio();
    aresetn <= 0;
    cyc(3);
    aresetn <= 1;
    bus(0, 8'hA8, 0);
    chk(rd_val, 0);
    final_report();
  end
endmodule
`default_nettype wire

/* File: sim/vectored_interrupt_map_sva.sv */
/* checker on the map's top ports
   assumes one clock and a synchronous active-low reset */
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_map_sva
  import irq_map_pkg::*;
(
  input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic        s_axi_wready, s_axi_bvalid, ext_input_zero, vector_ack,
  input wire logic        reti_done, instr_done, irq_request,
  input wire logic [15:0] irq_vector, boot_vector,
  input wire logic [3:0]  irq_order, hw_pending
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_ack; irq_request && vector_ack; endsequence
  property p_boot; boot_vector == 16'h0000; endproperty
  a_boot: assert property (p_boot) else $error("boot vector moved");
  property p_vec; irq_request |-> irq_vector == 16'h0003 + {9'h000, irq_order, 3'h0}; endproperty
  a_vec: assert property (p_vec) else $error("vector off order");
  property p_rsvd; irq_request |-> irq_order != 4'h8; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved slot used");
  property p_flag; ext_input_zero |=> hw_pending[0]; endproperty
  a_flag: assert property (p_flag) else $error("event lost");
  property p_clr; s_ack ##0 (irq_order == 4'h0 && !ext_input_zero) |=> !hw_pending[0]; endproperty
  a_clr: assert property (p_clr) else $error("flag kept after ack");
  property p_drop; s_ack |=> !irq_request; endproperty
  a_drop: assert property (p_drop) else $error("request kept after ack");
  property p_reti; reti_done && !instr_done |=> !irq_request; endproperty
  a_reti: assert property (p_reti) else $error("request before next instruction");
  property p_wr; s_wr |-> ##[1:2] s_axi_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write response late");
endmodule
bind vectored_interrupt_map vectored_interrupt_map_sva i_sva (.*);
`default_nettype wire
